// File: rtl/ntb_pkg.sv
package ntb_pkg;
	// configuration dword holding command (low half) and status (high half)
	localparam logic [11:0] NTB_CMDSTS_ADDR = 12'h004;
	localparam logic [11:0] NTB_STS_OFFSET = 12'h006;
	// command bit positions
	localparam int NTB_CMD_FWD_EN = 2;
	localparam int NTB_CMD_PERR_EN = 6;
	localparam int NTB_CMD_SERR_EN = 8;
	localparam int NTB_CMD_IRQ_DIS = 10;
	// status bit positions
	localparam int NTB_STS_IRQ_PEND = 3;
	localparam int NTB_STS_CAP_LIST = 4;
	localparam int NTB_STS_MDPE = 8;
	localparam int NTB_STS_RTA = 12;
	localparam int NTB_STS_RMA = 13;
	localparam int NTB_STS_SSE = 14;
	localparam int NTB_STS_DPE = 15;
	// reset values
	localparam logic NTB_CMD_BIT_RESET = 1'b0;
	localparam logic NTB_FLAG_RESET = 1'b0;
	localparam logic NTB_CAP_LIST_VALUE = 1'b1;
	localparam logic [31:0] NTB_RDATA_RESET = 32'h0000_0000;
	// read answer latency in cycles
	localparam int NTB_READ_LATENCY = 1;

	typedef enum logic [1:0] {
		NTB_REQ_MEM = 2'b00,
		NTB_REQ_IO = 2'b01,
		NTB_REQ_MSI = 2'b10,
		NTB_REQ_OTHER = 2'b11
	} ntb_req_kind_t;
endpackage : ntb_pkg

// File: rtl/ntb_flag_cell.sv
`timescale 1ns/100ps
`default_nettype none
module ntb_flag_cell (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// event and software clear
	input wire logic set_evt,
	input wire logic clr_w1c,
	// flag
	output logic flag_q
);
	import ntb_pkg::*;

	// an event in the clearing cycle must not be lost, so set wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag_q <= NTB_FLAG_RESET;
		end else if (set_evt) begin
			flag_q <= 1'b1;
		end else if (clr_w1c) begin
			flag_q <= 1'b0;
		end
	end
endmodule : ntb_flag_cell
`default_nettype wire

// File: rtl/ntb_cmdsts_regs.sv
// Summary of operation
// R1: forward-enable clear blocks memory, I/O, MSI requests; non-posted ones get UR.
// R2: forward-enable never affects completions or other request kinds.
// R3: with parity enable, poisoned completion, received or sent write sets master parity flag.
// R4: fatal and non-fatal errors are reported only while system error enable is set.
// R5: legacy IRQ disable set blocks INTx messages, never MSI; zero permits INTx.
// R6: external side never generates INTx regardless of the disable bit.
// R7: unused command bits and bits 15:11 are read-only zero.
// R8: pending bit shows only the device's own INTx, not forwarded emulation.
// R9: capability list bit is hardwired one and read-only.
// R10: status bits 2:0, 6, 5, 7, 10:9, 11 read as zero.
// R11: Completer Abort completion for own request sets received target abort flag.
// R12: Unsupported Request completion for own request sets received master abort flag.
// R13: sent fatal or non-fatal message with system error enable sets system error flag.
// R14: any received poisoned TLP sets detected parity flag, regardless of parity enable.
// R15: error flags clear on written one, keep on zero, set again on event.
// R16: master parity flag never sets while parity enable is clear.
`timescale 1ns/100ps
`default_nettype none
module ntb_cmdsts_regs (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// configuration access
	input wire logic CFG_WR,
	input wire logic CFG_RD,
	input wire logic [11:0] CFG_ADDR,
	input wire logic [3:0] CFG_BE,
	input wire logic [31:0] CFG_WDATA,
	output logic [31:0] CFG_RDATA,
	output logic CFG_RVALID,
	// request path
	input wire logic REQ_VALID,
	input wire ntb_pkg::ntb_req_kind_t REQ_KIND,
	input wire logic REQ_NONPOSTED,
	output logic REQ_FWD,
	output logic REQ_UR,
	// completion path
	input wire logic CPL_VALID,
	output logic CPL_FWD,
	// error events
	input wire logic RX_POIS_CPL,
	input wire logic RX_POIS_WR,
	input wire logic TX_POIS_WR,
	input wire logic RX_POIS_TLP,
	input wire logic RX_CPL_CA,
	input wire logic RX_CPL_UR,
	input wire logic ERR_DETECT,
	output logic ERR_MSG_SEND,
	// legacy interrupt
	input wire logic SIDE_EXTERNAL,
	input wire logic OWN_IRQ_PEND,
	input wire logic FWD_EMUL_IRQ,
	output logic INTX_ASSERT
);
	import ntb_pkg::*;

	logic fwd_en_reg;
	logic perr_en_reg;
	logic serr_en_reg;
	logic irq_dis_reg;
	logic irq_pend_reg;
	logic mdpe_q, rta_q, rma_q, sse_q, dpe_q;
	logic hit_wr, hit_rd;
	logic blocked_kind;
	logic [15:0] cmd_view, sts_view;
	logic mdpe_set, dpe_set, sse_set;

	assign hit_wr = CFG_WR && (CFG_ADDR == NTB_CMDSTS_ADDR);
	assign hit_rd = CFG_RD && (CFG_ADDR == NTB_CMDSTS_ADDR);

	// command bits; only the two low byte lanes (0 and 1) hold writable bits
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			fwd_en_reg <= NTB_CMD_BIT_RESET;
			perr_en_reg <= NTB_CMD_BIT_RESET;
			serr_en_reg <= NTB_CMD_BIT_RESET;
			irq_dis_reg <= NTB_CMD_BIT_RESET;
		end else if (hit_wr) begin
			if (CFG_BE[0]) begin
				fwd_en_reg <= CFG_WDATA[NTB_CMD_FWD_EN];
				perr_en_reg <= CFG_WDATA[NTB_CMD_PERR_EN];
			end
			if (CFG_BE[1]) begin
				serr_en_reg <= CFG_WDATA[NTB_CMD_SERR_EN];
				irq_dis_reg <= CFG_WDATA[NTB_CMD_IRQ_DIS];
			end
		end
	end

	// request gating; completions always pass
	assign blocked_kind = (REQ_KIND != NTB_REQ_OTHER) && !fwd_en_reg; // R1 R2
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			REQ_FWD <= 1'b0;
			REQ_UR <= 1'b0;
			CPL_FWD <= 1'b0;
		end else begin
			REQ_FWD <= REQ_VALID && !blocked_kind; // R1 R2
			REQ_UR <= REQ_VALID && blocked_kind && REQ_NONPOSTED; // R1
			CPL_FWD <= CPL_VALID; // R2
		end
	end

	// error message to the root complex
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ERR_MSG_SEND <= 1'b0;
		end else begin
			ERR_MSG_SEND <= ERR_DETECT && serr_en_reg; // R4
		end
	end

	// the external side has no INTx path at all, so the disable bit is moot there
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			irq_pend_reg <= 1'b0;
			INTX_ASSERT <= 1'b0;
		end else begin
			irq_pend_reg <= OWN_IRQ_PEND; // R8
			INTX_ASSERT <= OWN_IRQ_PEND && !irq_dis_reg && !SIDE_EXTERNAL; // R5 R6
		end
	end

	// flag set terms; forwarded emulation interrupts never reach the status
	assign mdpe_set = perr_en_reg && (RX_POIS_CPL || RX_POIS_WR || TX_POIS_WR); // R3 R16
	assign dpe_set = RX_POIS_TLP || RX_POIS_CPL || RX_POIS_WR; // R14
	assign sse_set = ERR_DETECT && serr_en_reg; // R13

	// write-one-to-clear flags all live in the upper status byte lane
	ntb_flag_cell u_mdpe (.clk(SYS_CLK), .rst(RST), .set_evt(mdpe_set), // R15
		.clr_w1c(hit_wr && CFG_BE[3] && CFG_WDATA[16 + NTB_STS_MDPE]), .flag_q(mdpe_q));
	ntb_flag_cell u_rta (.clk(SYS_CLK), .rst(RST), .set_evt(RX_CPL_CA), // R11 R15
		.clr_w1c(hit_wr && CFG_BE[3] && CFG_WDATA[16 + NTB_STS_RTA]), .flag_q(rta_q));
	ntb_flag_cell u_rma (.clk(SYS_CLK), .rst(RST), .set_evt(RX_CPL_UR), // R12 R15
		.clr_w1c(hit_wr && CFG_BE[3] && CFG_WDATA[16 + NTB_STS_RMA]), .flag_q(rma_q));
	ntb_flag_cell u_sse (.clk(SYS_CLK), .rst(RST), .set_evt(sse_set), // R13 R15
		.clr_w1c(hit_wr && CFG_BE[3] && CFG_WDATA[16 + NTB_STS_SSE]), .flag_q(sse_q));
	ntb_flag_cell u_dpe (.clk(SYS_CLK), .rst(RST), .set_evt(dpe_set), // R14 R15
		.clr_w1c(hit_wr && CFG_BE[3] && CFG_WDATA[16 + NTB_STS_DPE]), .flag_q(dpe_q));

	// read views; every unlisted bit is a constant zero
	always_comb begin
		cmd_view = 16'h0000; // R7
		cmd_view[NTB_CMD_FWD_EN] = fwd_en_reg;
		cmd_view[NTB_CMD_PERR_EN] = perr_en_reg;
		cmd_view[NTB_CMD_SERR_EN] = serr_en_reg;
		cmd_view[NTB_CMD_IRQ_DIS] = irq_dis_reg;
		sts_view = 16'h0000; // R10
		sts_view[NTB_STS_IRQ_PEND] = irq_pend_reg; // R8
		sts_view[NTB_STS_CAP_LIST] = NTB_CAP_LIST_VALUE; // R9
		sts_view[NTB_STS_MDPE] = mdpe_q;
		sts_view[NTB_STS_RTA] = rta_q;
		sts_view[NTB_STS_RMA] = rma_q;
		sts_view[NTB_STS_SSE] = sse_q;
		sts_view[NTB_STS_DPE] = dpe_q;
	end

	// other offsets belong to neighbouring header blocks and read zero here
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			CFG_RDATA <= NTB_RDATA_RESET;
			CFG_RVALID <= 1'b0;
		end else begin
			CFG_RVALID <= CFG_RD;
			CFG_RDATA <= hit_rd ? {sts_view, cmd_view} : NTB_RDATA_RESET;
		end
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	blocked_no_fwd_a: assert property (REQ_VALID && !fwd_en_reg && REQ_KIND != NTB_REQ_OTHER |=> !REQ_FWD) // R1
		else $error("blocked request was forwarded");
	blocked_np_ur_a: assert property (REQ_VALID && !fwd_en_reg && REQ_KIND != NTB_REQ_OTHER && REQ_NONPOSTED
		|=> REQ_UR) // R1
		else $error("blocked non-posted request got no UR");
	other_kind_pass_a: assert property (REQ_VALID && REQ_KIND == NTB_REQ_OTHER |=> REQ_FWD && !REQ_UR) // R2
		else $error("other request kind was gated");
	cpl_pass_a: assert property (CPL_VALID |=> CPL_FWD) // R2
		else $error("completion was not passed");
	mdpe_set_a: assert property (perr_en_reg && (RX_POIS_CPL || RX_POIS_WR || TX_POIS_WR) |=> mdpe_q) // R3
		else $error("master parity flag missed");
	err_report_a: assert property (ERR_DETECT |=> ERR_MSG_SEND == $past(serr_en_reg)) // R4
		else $error("error report not gated by enable");
	intx_gate_a: assert property (irq_dis_reg || SIDE_EXTERNAL |=> !INTX_ASSERT) // R5
		else $error("INTx raised while disabled");
	ext_no_intx_a: assert property (SIDE_EXTERNAL |=> !INTX_ASSERT) // R6
		else $error("external side raised INTx");
	cmd_ro_zero_a: assert property (CFG_RVALID |-> (CFG_RDATA[15:11] == 5'h00) && (CFG_RDATA[9] == 1'b0)
		&& (CFG_RDATA[7] == 1'b0) && (CFG_RDATA[5:3] == 3'h0)) // R7
		else $error("read-only command bits not zero");
	pend_track_a: assert property (hit_rd |=> CFG_RDATA[16 + NTB_STS_IRQ_PEND] == $past(irq_pend_reg)) // R8
		else $error("pending bit does not track own IRQ");
	emul_ignored_a: assert property (FWD_EMUL_IRQ && !OWN_IRQ_PEND |=> !irq_pend_reg) // R8
		else $error("forwarded emulation IRQ reached pending bit");
	cap_one_a: assert property (hit_rd |=> CFG_RDATA[16 + NTB_STS_CAP_LIST]) // R9
		else $error("capability bit not one");
	sts_ro_zero_a: assert property (CFG_RVALID |-> (CFG_RDATA[27:25] == 3'h0) && (CFG_RDATA[23:21] == 3'h0)
		&& (CFG_RDATA[18:16] == 3'h0)) // R10
		else $error("read-only status bits not zero");
	rta_set_a: assert property (RX_CPL_CA |=> rta_q) // R11
		else $error("target abort flag missed");
	rma_set_a: assert property (RX_CPL_UR |=> rma_q) // R12
		else $error("master abort flag missed");
	sse_set_a: assert property (ERR_DETECT && serr_en_reg |=> sse_q && ERR_MSG_SEND) // R13
		else $error("system error flag missed");
	dpe_set_a: assert property (RX_POIS_TLP |=> dpe_q) // R14
		else $error("detected parity flag missed");
	w1c_clear_a: assert property (hit_wr && CFG_BE[3] && CFG_WDATA[16 + NTB_STS_RTA] && !RX_CPL_CA |=> !rta_q) // R15
		else $error("write one did not clear flag");
	w1c_keep_a: assert property (rma_q && !(hit_wr && CFG_BE[3] && CFG_WDATA[16 + NTB_STS_RMA]) |=> rma_q) // R15
		else $error("flag lost without write one");
	mdpe_gate_a: assert property (!mdpe_q && !perr_en_reg |=> !mdpe_q) // R16
		else $error("master parity flag set while disabled");

	ur_cover_c: cover property (REQ_VALID && !fwd_en_reg && REQ_NONPOSTED ##1 REQ_UR);
	err_cover_c: cover property (ERR_DETECT && serr_en_reg ##1 ERR_MSG_SEND);
	clear_cover_c: cover property (dpe_q ##1 hit_wr && CFG_BE[3] ##1 !dpe_q);
	intx_cover_c: cover property (OWN_IRQ_PEND && !irq_dis_reg ##1 INTX_ASSERT);
endmodule : ntb_cmdsts_regs
`default_nettype wire

// File: tb/ntb_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module ntb_host_model (
	// bus clock
	input wire logic clk,
	// configuration request
	output logic cfg_wr,
	output logic cfg_rd,
	output logic [11:0] cfg_addr,
	output logic [3:0] cfg_be,
	output logic [31:0] cfg_wdata
);
	initial begin
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_addr = 12'hfff;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
	end
	// called just after an edge; one strobe per access, taken at the next edge
	task automatic access(input logic wr, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
		cfg_wr = wr;
		cfg_rd = ~wr;
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = d;
		@(posedge clk);
		#1;
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		// released lines never keep the last value, so stale data cannot pass
		cfg_addr = ~a;
		cfg_be = ~be;
		cfg_wdata = ~d;
	endtask : access
endmodule : ntb_host_model
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import ntb_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic cfg_wr, cfg_rd, cfg_rvalid, req_valid, req_np, req_fwd, req_ur, cpl_valid, cpl_fwd;
	logic err_msg, intx, ext, own, emul;
	logic [11:0] cfg_addr;
	logic [3:0] cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata, r;
	logic [6:0] ev;
	ntb_req_kind_t req_kind;
	logic [31:0] exp_q[$];
	int fails = 0;
	int compares = 0;
	always #10 sys_clk = ~sys_clk;
	ntb_host_model ntb_host_model_i (.clk(sys_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
		.cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
	ntb_cmdsts_regs ntb_cmdsts_regs_i (.SYS_CLK(sys_clk), .RST(rst), .CFG_WR(cfg_wr), .CFG_RD(cfg_rd),
		.CFG_ADDR(cfg_addr), .CFG_BE(cfg_be), .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata),
		.CFG_RVALID(cfg_rvalid), .REQ_VALID(req_valid), .REQ_KIND(req_kind), .REQ_NONPOSTED(req_np),
		.REQ_FWD(req_fwd), .REQ_UR(req_ur), .CPL_VALID(cpl_valid), .CPL_FWD(cpl_fwd), .RX_POIS_CPL(ev[6]),
		.RX_POIS_WR(ev[5]), .TX_POIS_WR(ev[4]), .RX_POIS_TLP(ev[3]), .RX_CPL_CA(ev[2]), .RX_CPL_UR(ev[1]),
		.ERR_DETECT(ev[0]), .ERR_MSG_SEND(err_msg), .SIDE_EXTERNAL(ext), .OWN_IRQ_PEND(own),
		.FWD_EMUL_IRQ(emul), .INTX_ASSERT(intx));
	task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
		compares++;
		if (got !== want) begin
			fails++;
			$display("ERROR %0t %s got %h want %h", $time, what, got, want);
		end
	endtask : check
	task automatic close_out();
		if (exp_q.size() != 0) begin
			fails++;
			$display("ERROR %0t %0d reads never answered", $time, exp_q.size());
		end
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out
	task automatic rd(input logic [11:0] a, input logic [31:0] want);
		exp_q.push_back(want);
		ntb_host_model_i.access(1'b0, a, 4'hf, 32'h0);
		@(posedge sys_clk);
		#1;
	endtask : rd
	task automatic wr(input logic [3:0] be, input logic [31:0] d);
		ntb_host_model_i.access(1'b1, NTB_CMDSTS_ADDR, be, d);
		// an idle edge keeps the next access from re-driving the strobe in the same step
		@(posedge sys_clk);
		#1;
	endtask : wr
	task automatic pulse(input logic [6:0] e);
		ev = e;
		@(posedge sys_clk);
		#1;
		ev = 7'h0;
	endtask : pulse
	// a completion rides along with every request; it must always pass
	task automatic req(input int k, input logic np, input logic fwd, input logic ur);
		req_valid = 1'b1;
		cpl_valid = 1'b1;
		req_kind = ntb_req_kind_t'(2'(k));
		req_np = np;
		@(posedge sys_clk);
		#1;
		req_valid = 1'b0;
		cpl_valid = 1'b0;
		req_kind = ntb_req_kind_t'(2'(~k));
		req_np = ~np;
		check({29'h0, req_fwd, req_ur, cpl_fwd}, {29'h0, fwd, ur, 1'b1}, "request path");
		@(posedge sys_clk);
		#1;
	endtask : req
	task automatic irq(input logic o, input logic e, input logic x, input logic want);
		own = o;
		emul = e;
		ext = x;
		repeat (2) @(posedge sys_clk);
		#1;
		check({31'h0, intx}, {31'h0, want}, "intx");
	endtask : irq
	always @(posedge sys_clk) begin
		if (cfg_rvalid === 1'b1) begin
			if (exp_q.size() == 0) check(32'h1, 32'h0, "unexpected read");
			else check(cfg_rdata, exp_q.pop_front(), "read data");
		end
	end
	initial begin
		#100us;
		fails++;
		$display("ERROR %0t watchdog expired", $time);
		close_out();
	end
	initial begin
		{req_valid, req_np, cpl_valid, ext, own, emul} = 6'h0;
		ev = 7'h0;
		req_kind = NTB_REQ_MEM;
		r = $urandom(35);
		repeat (5) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		rd(NTB_CMDSTS_ADDR, 32'h0010_0000);
		rd(12'h008, 32'h0);
		wr(4'hf, 32'hffff_ffff);
		rd(NTB_CMDSTS_ADDR, 32'h0010_0544);
		r = $urandom();
		wr(4'h3, r);
		rd(NTB_CMDSTS_ADDR, 32'h0010_0000 | (r & 32'h0544));
		$display("test registers done");
		wr(4'h3, 32'h0000_0004);
		for (int k = 0; k < 4; k++) req(k, 1'b1, 1'b1, 1'b0);
		wr(4'h3, 32'h0);
		for (int k = 0; k < 4; k++) begin
			req(k, 1'b1, k == 3, k != 3);
			req(k, 1'b0, k == 3, 1'b0);
		end
		$display("test forwarding done");
		pulse(7'h41);
		check({31'h0, err_msg}, 32'h0, "err msg blocked");
		rd(NTB_CMDSTS_ADDR, 32'h8010_0000);
		wr(4'h3, 32'h0000_0140);
		pulse(7'h17);
		check({31'h0, err_msg}, 32'h1, "err msg");
		rd(NTB_CMDSTS_ADDR, 32'hf110_0140);
		wr(4'h8, 32'h5000_0000);
		rd(NTB_CMDSTS_ADDR, 32'ha110_0140);
		wr(4'h7, 32'hffff_0140);
		pulse(7'h04);
		rd(NTB_CMDSTS_ADDR, 32'hb110_0140);
		wr(4'h8, 32'hff00_0000);
		rd(NTB_CMDSTS_ADDR, 32'h0010_0140);
		$display("test flags done");
		irq(1'b1, 1'b0, 1'b0, 1'b1);
		wr(4'h3, 32'h0000_0540);
		irq(1'b1, 1'b0, 1'b0, 1'b0);
		rd(NTB_CMDSTS_ADDR, 32'h0018_0540);
		wr(4'h3, 32'h0000_0140);
		irq(1'b0, 1'b1, 1'b0, 1'b0);
		rd(NTB_CMDSTS_ADDR, 32'h0010_0140);
		irq(1'b1, 1'b0, 1'b1, 1'b0);
		$display("test interrupt done");
		close_out();
	end
endmodule : tb_top
`default_nettype wire
